// file: src/acc_pkg.sv
// Shared constants, encodings and state types of the accumulator slice
package acc_pkg;
    // Widths
    localparam int unsigned ACC_DATA_W = 32;
    localparam int unsigned ACC_OVC_W  = 6;
    localparam int unsigned ACC_RPT_W  = 8;

    // Register byte offsets (low address byte)
    localparam logic [7:0] ACC_OFS_SUM    = 8'h00;
    localparam logic [7:0] ACC_OFS_STATUS = 8'h04;
    localparam logic [7:0] ACC_OFS_OVC    = 8'h08;
    localparam logic [7:0] ACC_OFS_RPT    = 8'h0c;
    localparam logic [7:0] ACC_OFS_INSTR  = 8'h10;

    // Status register field positions
    localparam int unsigned ACC_ST_CARRY   = 0;
    localparam int unsigned ACC_ST_ZERO    = 1;
    localparam int unsigned ACC_ST_NEG     = 2;
    localparam int unsigned ACC_ST_OVF     = 3;
    localparam int unsigned ACC_ST_TEST    = 4;
    localparam int unsigned ACC_ST_SAT     = 5;
    localparam int unsigned ACC_ST_SXM     = 6;
    localparam int unsigned ACC_ST_OBJ     = 7;
    localparam int unsigned ACC_ST_ILLEGAL = 8;

    // Opcodes and saturation limits
    localparam logic [15:0] ACC_OPC_ABS     = 16'hff56;
    localparam logic [15:0] ACC_OPC_MAGNITUDE_SIGN_TOGGLE_OP   = 16'h565f;
    localparam logic [11:0] ACC_OPC_ADDI_HI = 12'hff1;
    localparam logic [31:0] ACC_MAX_POS     = 32'h7fff_ffff;
    localparam logic [31:0] ACC_MAX_NEG     = 32'h8000_0000;

    // Bus encodings
    localparam logic [2:0] ACC_HSIZE_WORD = 3'h2;

    // Reset values
    localparam logic [31:0] ACC_SUM_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        ACC_OP_NONE  = 4'h1,
        ACC_OP_ABS   = 4'h2,
        ACC_OP_MAGNITUDE_SIGN_TOGGLE_OP = 4'h4,
        ACC_OP_ADDI  = 4'h8
    } acc_op_type;

    typedef enum logic [1:0] {
        ACC_BUS_IDLE = 2'h1,
        ACC_BUS_DATA = 2'h2
    } acc_bus_type;

    typedef struct packed {
        acc_bus_type          bus_state;
        logic [7:0]           addr;
        logic                 write;
        logic                 size_ok;
        logic                 hreadyout;
        logic                 hresp;
        logic [31:0]          hrdata;
        logic [31:0]          sum;
        logic                 carry;
        logic                 zero;
        logic                 neg;
        logic                 ovf;
        logic                 test_flag;
        logic                 saturate_enable;
        logic                 sign_ext_mode;
        logic                 object_code_mode_bit;
        logic                 illegal;
        logic [ACC_OVC_W-1:0] ovc;
        logic [ACC_RPT_W-1:0] repeat_count;
        logic [31:0]          instr;
    } acc_core_state_type;
endpackage : acc_pkg

// file: src/acc_alu_if.sv
// Operation request and result bundle between the core and its arithmetic unit
`timescale 1ns/10ps
interface acc_alu_if;
    import acc_pkg::*;
    acc_op_type  op;
    logic [31:0] sum_in;
    logic [15:0] imm16;
    logic [3:0]  shift_amount_field;
    logic        saturate_enable;
    logic        sign_ext_mode;
    logic [31:0] result;
    logic        carry;
    logic        zero;
    logic        neg;
    logic        ovf_set;
    logic        toggle_test;
    logic        ovc_inc;
    logic        ovc_dec;

    modport core (output op, sum_in, imm16, shift_amount_field, saturate_enable,
                  sign_ext_mode,
                  input  result, carry, zero, neg, ovf_set, toggle_test, ovc_inc, ovc_dec);
    modport alu  (input  op, sum_in, imm16, shift_amount_field, saturate_enable,
                  sign_ext_mode,
                  output result, carry, zero, neg, ovf_set, toggle_test, ovc_inc, ovc_dec);
endinterface : acc_alu_if

// file: src/acc_alu.sv
// Single-cycle arithmetic for magnitude and shifted-immediate add
`timescale 1ns/10ps
module acc_alu (
    // Operation and result
    acc_alu_if.alu io
);
    import acc_pkg::*;

    logic [31:0] ext_imm;
    logic [31:0] shifted;
    logic [32:0] wide_sum;
    logic        most_neg;
    logic        add_ovf;

    always_comb begin
        ext_imm  = io.sign_ext_mode ? {{16{io.imm16[15]}}, io.imm16}
                                    : {16'h0000, io.imm16};
        shifted  = ext_imm << io.shift_amount_field;
        wide_sum = {1'b0, io.sum_in} + {1'b0, shifted};
        add_ovf  = (io.sum_in[31] == shifted[31]) && (wide_sum[31] != io.sum_in[31]);
        most_neg = (io.sum_in == ACC_MAX_NEG);
        io.result      = io.sum_in;
        io.carry       = 1'b0;
        io.ovf_set     = 1'b0;
        io.toggle_test = 1'b0;
        io.ovc_inc     = 1'b0;
        io.ovc_dec     = 1'b0;
        case (io.op)
            ACC_OP_ABS, ACC_OP_MAGNITUDE_SIGN_TOGGLE_OP: begin
                io.carry       = 1'b0;
                io.toggle_test = io.sum_in[31];
                if (most_neg) begin
                    io.ovf_set = 1'b1;
                    io.result  = io.saturate_enable ? ACC_MAX_POS : ACC_MAX_NEG;
                end else if (io.sum_in[31]) begin
                    io.result = 32'h0000_0000 - io.sum_in;
                end
            end
            ACC_OP_ADDI: begin
                io.carry   = wide_sum[32];
                io.ovf_set = add_ovf;
                // Positive overflow only happens from a non-negative start
                io.ovc_inc = add_ovf && !io.sum_in[31] && !io.saturate_enable;
                io.ovc_dec = add_ovf && io.sum_in[31] && !io.saturate_enable;
                if (add_ovf && io.saturate_enable) begin
                    io.result = io.sum_in[31] ? ACC_MAX_NEG : ACC_MAX_POS;
                end else begin
                    io.result = wide_sum[31:0];
                end
            end
            default: begin
                io.result = io.sum_in;
            end
        endcase
        io.neg  = io.result[31];
        io.zero = (io.result == 32'h0000_0000);
    end
endmodule : acc_alu

// file: src/acc_core.sv
// Accumulator slice with its mode bits, flags and counters behind an AHB-Lite slave
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps

module acc_core (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AHB-Lite address phase
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    // AHB-Lite data phase
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    import acc_pkg::*;

    acc_core_state_type s;
    acc_core_state_type next_s;

    acc_alu_if alu_bus ();

    acc_alu u_alu (
        .io (alu_bus.alu)
    );

    logic                 bus_start;
    logic                 wr_now;
    logic                 rd_now;
    logic [15:0]          first_word;
    logic [15:0]          second_word;
    acc_op_type           decoded_op;
    logic                 decode_bad;
    logic                 exec;
    logic [31:0]          status_word;
    logic [31:0]          read_word;

    // Address phase is only taken while no data phase is outstanding
    assign bus_start = hsel && htrans[1] && hready &&
                       (s.bus_state == ACC_BUS_IDLE);
    assign wr_now    = (s.bus_state == ACC_BUS_DATA) && s.write && s.size_ok;
    assign rd_now    = (s.bus_state == ACC_BUS_DATA) && !s.write;

    // Instruction word split: first opcode word low, operand word high
    assign first_word  = hwdata[15:0];
    assign second_word = hwdata[31:16];

    // Opcode decode for a write to the instruction register
    always_comb begin
        decoded_op = ACC_OP_NONE;
        decode_bad = 1'b0;
        if (first_word == ACC_OPC_ABS) begin
            decoded_op = ACC_OP_ABS;
        end else if (first_word == ACC_OPC_MAGNITUDE_SIGN_TOGGLE_OP) begin
            // The toggle form only exists in the newer object mode
            if (s.object_code_mode_bit) begin
                decoded_op = ACC_OP_MAGNITUDE_SIGN_TOGGLE_OP;
            end else begin
                decode_bad = 1'b1;
            end
        end else if (first_word[15:4] == ACC_OPC_ADDI_HI) begin
            decoded_op = ACC_OP_ADDI;
        end else begin
            decode_bad = 1'b1;
        end
    end

    assign exec = wr_now && (s.addr == ACC_OFS_INSTR) && (decoded_op != ACC_OP_NONE);

    // Operands handed to the arithmetic unit
    always_comb begin
        alu_bus.op                 = exec ? decoded_op : ACC_OP_NONE;
        alu_bus.sum_in             = s.sum;
        alu_bus.imm16              = second_word;
        alu_bus.shift_amount_field = first_word[3:0];
        alu_bus.saturate_enable    = s.saturate_enable;
        alu_bus.sign_ext_mode      = s.sign_ext_mode;
    end

    // Status word as seen by software
    always_comb begin
        status_word                 = 32'h0000_0000;
        status_word[ACC_ST_CARRY]   = s.carry;
        status_word[ACC_ST_ZERO]    = s.zero;
        status_word[ACC_ST_NEG]     = s.neg;
        status_word[ACC_ST_OVF]     = s.ovf;
        status_word[ACC_ST_TEST]    = s.test_flag;
        status_word[ACC_ST_SAT]     = s.saturate_enable;
        status_word[ACC_ST_SXM]     = s.sign_ext_mode;
        status_word[ACC_ST_OBJ]     = s.object_code_mode_bit;
        status_word[ACC_ST_ILLEGAL] = s.illegal;
    end

    // Read multiplexer; unmapped offsets read as zero
    always_comb begin
        read_word = 32'h0000_0000;
        case (s.addr)
            ACC_OFS_SUM: begin
                read_word = s.sum;
            end
            ACC_OFS_STATUS: begin
                read_word = status_word;
            end
            ACC_OFS_OVC: begin
                // Counter is signed, so it reads sign extended
                read_word = {{(32 - ACC_OVC_W){s.ovc[ACC_OVC_W-1]}}, s.ovc};
            end
            ACC_OFS_RPT: begin
                read_word = {{(32 - ACC_RPT_W){1'b0}}, s.repeat_count};
            end
            ACC_OFS_INSTR: begin
                read_word = s.instr;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        next_s       = s;
        next_s.hresp = 1'b0;

        // Bus sequencing: one wait state gives registered read data
        // without a path from hwdata to hrdata in the same cycle
        case (s.bus_state)
            ACC_BUS_IDLE: begin
                next_s.hreadyout = 1'b1;
                if (bus_start) begin
                    next_s.addr      = haddr[7:0];
                    next_s.write     = hwrite;
                    next_s.size_ok   = (hsize == ACC_HSIZE_WORD);
                    next_s.hreadyout = 1'b0;
                    next_s.bus_state = ACC_BUS_DATA;
                end
            end
            ACC_BUS_DATA: begin
                next_s.hreadyout = 1'b1;
                next_s.bus_state = ACC_BUS_IDLE;
                next_s.hrdata    = rd_now ? read_word : 32'h0000_0000;
            end
            default: begin
                next_s.hreadyout = 1'b1;
                next_s.bus_state = ACC_BUS_IDLE;
            end
        endcase

        // Plain software writes
        if (wr_now) begin
            case (s.addr)
                ACC_OFS_SUM: begin
                    next_s.sum = hwdata;
                end
                ACC_OFS_STATUS: begin
                    next_s.carry                = hwdata[ACC_ST_CARRY];
                    next_s.zero                 = hwdata[ACC_ST_ZERO];
                    next_s.neg                  = hwdata[ACC_ST_NEG];
                    next_s.ovf                  = hwdata[ACC_ST_OVF];
                    next_s.test_flag            = hwdata[ACC_ST_TEST];
                    next_s.saturate_enable      = hwdata[ACC_ST_SAT];
                    next_s.sign_ext_mode        = hwdata[ACC_ST_SXM];
                    next_s.object_code_mode_bit = hwdata[ACC_ST_OBJ];
                end
                ACC_OFS_OVC: begin
                    next_s.ovc = hwdata[ACC_OVC_W-1:0];
                end
                ACC_OFS_RPT: begin
                    next_s.repeat_count = hwdata[ACC_RPT_W-1:0];
                end
                ACC_OFS_INSTR: begin
                    next_s.instr = hwdata;
                end
                default: begin
                    next_s.instr = s.instr;
                end
            endcase
        end

        // Illegal-opcode flag: write one to clear, a new event wins
        if (wr_now && (s.addr == ACC_OFS_STATUS) && hwdata[ACC_ST_ILLEGAL]) begin
            next_s.illegal = 1'b0;
        end
        if (wr_now && (s.addr == ACC_OFS_INSTR) && decode_bad) begin
            next_s.illegal = 1'b1;
        end

        // Executing an operation
        if (exec) begin
            // A pending repeat prefix is dropped; the operation runs once
            next_s.repeat_count = '0;
            next_s.sum          = alu_bus.result;
            next_s.carry        = alu_bus.carry;
            next_s.zero         = alu_bus.zero;
            next_s.neg          = alu_bus.neg;
            if (alu_bus.ovf_set) begin
                next_s.ovf = 1'b1;
            end else begin
                next_s.ovf = s.ovf;
            end
            if ((decoded_op == ACC_OP_MAGNITUDE_SIGN_TOGGLE_OP) && alu_bus.toggle_test) begin
                next_s.test_flag = !s.test_flag;
            end
            // Counter wraps; software reads it before it can run away
            if (alu_bus.ovc_inc) begin
                next_s.ovc = s.ovc + ACC_OVC_W'(1);
            end else if (alu_bus.ovc_dec) begin
                next_s.ovc = s.ovc - ACC_OVC_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '{bus_state:            ACC_BUS_IDLE,
                   addr:                 8'h00,
                   write:                1'b0,
                   size_ok:              1'b0,
                   hreadyout:            1'b1,
                   hresp:                1'b0,
                   hrdata:               32'h0000_0000,
                   sum:                  ACC_SUM_RST,
                   carry:                1'b0,
                   zero:                 1'b0,
                   neg:                  1'b0,
                   ovf:                  1'b0,
                   test_flag:            1'b0,
                   saturate_enable:      1'b0,
                   sign_ext_mode:        1'b0,
                   object_code_mode_bit: 1'b0,
                   illegal:              1'b0,
                   ovc:                  '0,
                   repeat_count:         '0,
                   instr:                32'h0000_0000};
        end else begin
            s <= next_s;
        end
    end

    // Bus outputs straight from the state register
    assign hrdata    = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp     = s.hresp;
endmodule : acc_core

// file: dv/acc_core_chk.sv
// Bus-side checks of the accumulator slice
`timescale 1ns/10ps
module acc_core_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Address phase
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    // Data phase
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp
);
    import acc_pkg::*;
    logic        dv, dw, abs_op, ran_op, fresh, exec;
    logic [7:0]  da;
    logic [31:0] sv;
    logic        take, wend, rend, is_abs, is_add;
    assign take = hsel && htrans[1] && hready;
    assign wend = dv && dw && hready;
    assign rend = dv && !dw && hready;
    assign is_abs = hwdata[15:0] == ACC_OPC_ABS;
    assign is_add = hwdata[15:4] == ACC_OPC_ADDI_HI;

    // Flags say what the last executed op lets a later read show; any
    // software write to the sum or flags voids them, except exec, which only a repeat-count write clears
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dv <= 1'b0;
            abs_op <= 1'b0;
            ran_op <= 1'b0;
            fresh <= 1'b0;
            exec <= 1'b0;
        end else begin
            if (hready) begin
                dv <= take;
            end
            if (take) begin
                da <= haddr[7:0];
                dw <= hwrite;
            end
            if (wend && da == ACC_OFS_INSTR) begin
                abs_op <= is_abs || (abs_op && !is_add);
                ran_op <= ran_op || is_abs || is_add;
                exec <= exec || is_abs || is_add;
                fresh <= 1'b0;
            end
            if (wend && (da == ACC_OFS_SUM || da == ACC_OFS_STATUS)) begin
                abs_op <= 1'b0;
                ran_op <= 1'b0;
                fresh <= 1'b0;
            end
            if (wend && da == ACC_OFS_RPT) begin
                exec <= 1'b0;
            end
            if (rend && da == ACC_OFS_SUM) begin
                fresh <= 1'b1;
                sv <= hrdata;
            end
        end
    end

    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_wait_state;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_status_rd;
        rend && da == ACC_OFS_STATUS;
    endsequence

    AST_WAIT: assert property (take |=> s_wait_state)
        else $error("data phase not one wait state");
    AST_OKAY: assert property (dv |-> !hresp)
        else $error("error response seen");
    AST_RPT: assert property (rend && da == ACC_OFS_RPT && exec |-> hrdata == 32'h0)
        else $error("repeat count kept after op");
    AST_CARRY: assert property (s_status_rd ##0 abs_op |-> !hrdata[ACC_ST_CARRY])
        else $error("carry left set by magnitude");
    AST_ZERO: assert property (s_status_rd ##0 (ran_op && fresh)
        |-> hrdata[ACC_ST_ZERO] == (sv == 32'h0)) else $error("zero flag wrong");
    AST_NEG: assert property (s_status_rd ##0 (ran_op && fresh)
        |-> hrdata[ACC_ST_NEG] == sv[31]) else $error("negative flag wrong");
    AST_ABSPOS: assert property (rend && da == ACC_OFS_SUM && abs_op
        |-> !hrdata[31] || hrdata == ACC_MAX_NEG) else $error("magnitude negative");
    AST_ABSOVF: assert property (s_status_rd ##0 (abs_op && fresh && sv == ACC_MAX_NEG)
        |-> hrdata[ACC_ST_OVF] && !hrdata[ACC_ST_SAT]) else $error("limit case wrong");
endmodule : acc_core_chk

// file: dv/acc_mst.sv
// Bus master model standing in for the core that issues register traffic
`timescale 1ns/10ps
module acc_mst (
    // Clock
    input wire logic        ref_clk,
    // Bus requests
    output logic            hsel,
    output logic [31:0]     haddr,
    output logic [1:0]      htrans,
    output logic            hwrite,
    output logic [2:0]      hsize,
    output logic [31:0]     hwdata,
    // Bus answers
    input wire logic        hready,
    input wire logic [31:0] hrdata
);
    import acc_pkg::*;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = ACC_HSIZE_WORD;
        hwdata = 32'h0;
    end
    // Slave outputs update in the NBA region, so values read right after
    // the rising edge are the ones that edge sampled
    task automatic edge_rdy(output logic rdy, output logic [31:0] q);
        int n;
        n = 0;
        rdy = 1'b0;
        while (!rdy && n < 40) begin
            @(posedge ref_clk);
            rdy = (hready === 1'b1);
            q = hrdata;
            n++;
        end
    endtask : edge_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        logic r1;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        edge_rdy(r1, q);
        htrans <= 2'h0;
        haddr <= ~{24'h0, a};
        hwdata <= w ? d : ~hwdata;
        edge_rdy(ok, q);
        ok = ok && r1;
        hwdata <= ~d;
    endtask : xfer
endmodule : acc_mst

// file: dv/tb.sv
// Self-checking bench for the accumulator slice
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
    import acc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int          n_mismatch = 0;
    int          checked = 0;
    localparam logic [31:0] MV [6] = '{32'h5, 32'hffff_fffb, 32'h0, 32'h8000_0000,
                                       32'h7fff_ffff, 32'h8000_0000};
    localparam logic [31:0] MS [6] = '{32'h1, 32'h19, 32'h1, 32'h10, 32'h21, 32'h31};
    localparam logic [31:0] AA [8] = '{32'h0, 32'h0, 32'hffff_ffff, 32'h7fff_ffff,
        32'h7fff_ffff, 32'h8000_0000, 32'h8000_0000, 32'h10};
    localparam logic [15:0] AI [8] = '{16'h8000, 16'h8000, 16'h1, 16'h1, 16'h1,
        16'hffff, 16'hffff, 16'h1};
    localparam logic [3:0] AH [8] = '{4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'hf, 4'hf, 4'h0};
    localparam logic [31:0] AS [8] = '{32'h40, 32'h1, 32'h0, 32'h0, 32'h20, 32'h40,
        32'h60, 32'h8};

    // Held high in reset so the slave never sees an unknown ready
    assign hready = rst | hreadyout;
    always #2.5 ref_clk = ~ref_clk;
    acc_core i_acc_core (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    acc_mst i_acc_mst (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

    task automatic conclude();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic ok;
        i_acc_mst.xfer(w, a, d, q, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t no answer", $time);
            conclude();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask : chk_rd

    task automatic run_mag(input logic [15:0] op, input logic [31:0] v, st);
        logic [31:0] r, es;
        logic        mn;
        mn = (v == ACC_MAX_NEG);
        r = mn ? (st[ACC_ST_SAT] ? ACC_MAX_POS : ACC_MAX_NEG) : (v[31] ? -v : v);
        es = st;
        es[ACC_ST_CARRY] = 1'b0;
        es[ACC_ST_ZERO] = (r == 32'h0);
        es[ACC_ST_NEG] = r[31];
        es[ACC_ST_OVF] = st[ACC_ST_OVF] | mn;
        es[ACC_ST_TEST] = st[ACC_ST_TEST] ^ (v[31] && op == ACC_OPC_MAGNITUDE_SIGN_TOGGLE_OP);
        wr(ACC_OFS_STATUS, st);
        wr(ACC_OFS_RPT, 32'h3);
        wr(ACC_OFS_SUM, v);
        wr(ACC_OFS_INSTR, {16'h0, op});
        chk_rd(ACC_OFS_SUM, r);
        chk_rd(ACC_OFS_STATUS, es);
        chk_rd(ACC_OFS_RPT, 32'h0);
    endtask : run_mag

    task automatic run_add(input logic [31:0] a, input logic [15:0] imm,
                           input logic [3:0] sh, input logic [31:0] st);
        logic [31:0] k, r, es, eo;
        logic [32:0] s;
        logic        ov;
        k = (st[ACC_ST_SXM] ? {{16{imm[15]}}, imm} : {16'h0, imm}) << sh;
        s = {1'b0, a} + {1'b0, k};
        ov = (a[31] == k[31]) && (s[31] != a[31]);
        r = (ov && st[ACC_ST_SAT]) ? (a[31] ? ACC_MAX_NEG : ACC_MAX_POS) : s[31:0];
        eo = (ov && !st[ACC_ST_SAT]) ? (a[31] ? 32'hffff_ffff : 32'h1) : 32'h0;
        es = st;
        es[ACC_ST_CARRY] = s[32];
        es[ACC_ST_ZERO] = (r == 32'h0);
        es[ACC_ST_NEG] = r[31];
        es[ACC_ST_OVF] = st[ACC_ST_OVF] | ov;
        wr(ACC_OFS_STATUS, st);
        wr(ACC_OFS_RPT, 32'h3);
        wr(ACC_OFS_SUM, a);
        wr(ACC_OFS_OVC, 32'h0);
        wr(ACC_OFS_INSTR, {imm, ACC_OPC_ADDI_HI, sh});
        chk_rd(ACC_OFS_SUM, r);
        chk_rd(ACC_OFS_STATUS, es);
        chk_rd(ACC_OFS_OVC, eo);
        chk_rd(ACC_OFS_RPT, 32'h0);
    endtask : run_add

    task automatic t_reset();
        wr(8'h14, 32'hffff_ffff);
        chk_rd(ACC_OFS_SUM, ACC_SUM_RST);
        chk_rd(ACC_OFS_STATUS, 32'h0);
        chk_rd(ACC_OFS_OVC, 32'h0);
        chk_rd(ACC_OFS_RPT, 32'h0);
        chk_rd(8'h14, 32'h0);
        // Unknown opcode must not execute and must raise the illegal flag
        wr(ACC_OFS_SUM, 32'h0000_0005);
        wr(ACC_OFS_INSTR, 32'h0000_1234);
        chk_rd(ACC_OFS_SUM, 32'h0000_0005);
        chk_rd(ACC_OFS_STATUS, 32'h100);
        wr(ACC_OFS_STATUS, 32'h100);
        chk_rd(ACC_OFS_STATUS, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_mag();
        for (int i = 0; i < 12; i++) begin
            run_mag(i < 6 ? ACC_OPC_ABS : ACC_OPC_MAGNITUDE_SIGN_TOGGLE_OP, MV[i % 6],
                    MS[i % 6] | (i < 6 ? 32'h0 : 32'h80));
        end
        // Toggle variant outside the newer object mode must leave the sum alone and raise the illegal flag
        wr(ACC_OFS_STATUS, 32'h0);
        wr(ACC_OFS_SUM, 32'hffff_fffb);
        wr(ACC_OFS_INSTR, {16'h0, ACC_OPC_MAGNITUDE_SIGN_TOGGLE_OP});
        chk_rd(ACC_OFS_SUM, 32'hffff_fffb);
        chk_rd(ACC_OFS_STATUS, 32'h100);
        wr(ACC_OFS_STATUS, 32'h100);
        $display("magnitude test done");
    endtask : t_mag

    task automatic t_add();
        for (int i = 0; i < 8; i++) begin
            run_add(AA[i], AI[i], AH[i], AS[i]);
        end
        for (int s = 0; s < 16; s++) begin
            run_add(32'h0, 16'h3, 4'(s), 32'h0);
        end
        $display("add test done");
    endtask : t_add

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_mag();
        t_add();
        conclude();
    end
endmodule : tb

bind acc_core acc_core_chk i_acc_core_chk (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
